// file: hdl/mrc_map.vh
// Register map, field positions and codes of the measurement run control.
`ifndef MRC_MAP_VH
`define MRC_MAP_VH
`define MRC_ADR_CTRL     3'h0
`define MRC_ADR_CMD      3'h1
`define MRC_ADR_STATUS   3'h2
`define MRC_ADR_ERROR    3'h3
`define MRC_ADR_COUNT    3'h4
`define MRC_ADR_STATCNT  3'h5
`define MRC_ADR_PASSCNT  3'h6
`define MRC_ADR_FAILCNT  3'h7
`define MRC_CTRL_W       14
`define MRC_CTRL_MASK    14'h377e
`define MRC_CTRL_RST     14'h0000
`define MRC_B_CONT       0
`define MRC_B_STOPFAIL   1
`define MRC_B_ABC        2
`define MRC_B_STATEN     3
`define MRC_B_LIMEN      4
`define MRC_B_SELFCLR    5
`define MRC_B_SELFTRIG   6
`define MRC_FN_LO        8
`define MRC_FN_HI        10
`define MRC_GA_LO        12
`define MRC_GA_HI        13
`define MRC_C_CONT_ON    0
`define MRC_C_CONT_OFF   1
`define MRC_C_SINGLE     2
`define MRC_C_CANCEL     3
`define MRC_C_STDRST     4
`define MRC_S_RUN        2
`define MRC_S_BLOCK      3
`define MRC_S_STATCOMP   8
`define MRC_FN_SPECIAL   3'h4
`define MRC_GA_SINGLE    2'h0
`define MRC_GA_CANCEL    2'h1
`define MRC_GA_CONT      2'h2
`define MRC_ERR_INIT     16'hff2b
`define MRC_ERR_TRIG     16'hff2e
`define MRC_CNT_W        16
`define MRC_COUNT_RST    16'h0001
`endif

// file: hdl/mrc_cnt.v
// Event counter with synchronous clear, used for run statistics.
module mrc_cnt #(
	parameter W = 16
) (
	// System
	input  wire         clk_i,
	input  wire         rst_i,
	// Control
	input  wire         clr_i,
	input  wire         inc_i,
	// Count
	output reg  [W-1:0] count_o
);
	// An event in the clearing cycle is kept as the first count.
	always @(posedge clk_i)
	begin
		if (rst_i || clr_i)
			count_o <= {{(W-1){1'b0}}, inc_i & ~rst_i};
		else if (inc_i)
			count_o <= count_o + {{(W-1){1'b0}}, 1'b1};
	end
endmodule // mrc_cnt

// file: hdl/mrc_wbif.v
// Classic Wishbone handshake: one wait state, then a single-cycle ack.
module mrc_wbif (
	// System
	input  wire clk_i,
	input  wire rst_i,
	// Bus request
	input  wire cyc_i,
	input  wire stb_i,
	input  wire we_i,
	// Handshake
	output reg  ack_o,
	output wire wr_o,
	output wire rd_o
);
	// Ack drops the cycle after it was given, so each request acks once.
	always @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i & stb_i & ~ack_o;
	end

	// Writes land on the edge at which the master samples ack.
	assign wr_o = cyc_i & stb_i & we_i & ack_o;
	assign rd_o = cyc_i & stb_i & ~we_i & ~ack_o;
endmodule // mrc_wbif

// file: hdl/mrc_top.v
// Measurement run control with its Wishbone register file.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`include "mrc_map.vh"
module mrc_top (
	// System
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [4:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// Instrument bus trigger
	input  wire        get_i,
	input  wire        listen_i,
	// Measurement engine
	input  wire        meas_done_i,
	input  wire        limit_fail_i,
	input  wire        limit_pass_i,
	output reg         meas_start_o,
	output reg         meas_cancel_o,
	output reg         auto_trigger_o,
	output reg         stats_clear_o,
	output reg         limit_clear_o,
	// Status
	output reg         limit_detect_o,
	output reg         limit_annunciator_o,
	output reg         pending_op_o,
	output reg         err_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg                    state;
	reg                    cont;
	reg                    block_mode;
	reg                    stat_comp;
	reg [`MRC_CTRL_W-1:0]  cfg;
	reg [`MRC_CNT_W-1:0]   repeat_count;
	reg [`MRC_CNT_W-1:0]   left;
	reg [15:0]             err_code;

	wire                   wr;
	wire                   rd;
	wire [2:0]             adr;
	wire [31:0]            lane;
	wire [`MRC_CNT_W-1:0]  stat_cnt;
	wire [`MRC_CNT_W-1:0]  pass_cnt;
	wire [`MRC_CNT_W-1:0]  fail_cnt;

	reg                    cmd_on;
	reg                    cmd_off;
	reg                    cmd_single;
	reg                    cmd_cancel;
	reg                    cmd_rst;
	reg                    next_fail;

	wire                   self_clr;
	wire                   self_trig;
	wire                   want_block;
	wire [2:0]             func;
	wire [1:0]             gaction;
	wire                   get_hit;

	assign adr       = wb_adr_i[4:2];
	assign lane      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign self_clr  = cfg[`MRC_B_SELFCLR];
	assign self_trig = cfg[`MRC_B_SELFTRIG];
	assign func      = cfg[`MRC_FN_HI:`MRC_FN_LO];
	assign gaction   = cfg[`MRC_GA_HI:`MRC_GA_LO];
	assign get_hit   = get_i & listen_i;
	// Block decision
	assign want_block = cfg[`MRC_B_ABC] & cfg[`MRC_B_STATEN] &
	                    (func < `MRC_FN_SPECIAL);

	mrc_wbif u_wbif (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (wb_cyc_i),
		.stb_i (wb_stb_i),
		.we_i  (wb_we_i),
		.ack_o (wb_ack_o),
		.wr_o  (wr),
		.rd_o  (rd)
	);

	// Command decode; a group trigger acts like the configured command.
	always @*
	begin
		cmd_on     = 1'b0;
		cmd_off    = 1'b0;
		cmd_single = 1'b0;
		cmd_cancel = 1'b0;
		cmd_rst    = 1'b0;
		if (wr && adr == `MRC_ADR_CMD && wb_sel_i[0])
		begin
			cmd_on     = wb_dat_i[`MRC_C_CONT_ON];
			cmd_off    = wb_dat_i[`MRC_C_CONT_OFF];
			cmd_single = wb_dat_i[`MRC_C_SINGLE];
			cmd_cancel = wb_dat_i[`MRC_C_CANCEL];
			cmd_rst    = wb_dat_i[`MRC_C_STDRST];
		end
		if (get_hit)
		begin
			case (gaction)
			`MRC_GA_SINGLE: cmd_single = 1'b1;
			`MRC_GA_CANCEL: cmd_cancel = 1'b1;
			`MRC_GA_CONT:   cmd_on = 1'b1;
			default:        cmd_single = cmd_single;
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state          <= ST_IDLE;
			cont           <= 1'b1;
			block_mode     <= 1'b0;
			stat_comp      <= 1'b0;
			cfg            <= `MRC_CTRL_RST;
			repeat_count   <= `MRC_COUNT_RST;
			left           <= {`MRC_CNT_W{1'b0}};
			err_code       <= 16'h0000;
			meas_start_o   <= 1'b0;
			meas_cancel_o  <= 1'b0;
			auto_trigger_o <= 1'b0;
			stats_clear_o  <= 1'b0;
			limit_clear_o  <= 1'b0;
			pending_op_o   <= 1'b0;
			err_o          <= 1'b0;
		end
		else
		begin
			meas_start_o   <= 1'b0;
			meas_cancel_o  <= 1'b0;
			auto_trigger_o <= 1'b0;
			stats_clear_o  <= 1'b0;
			limit_clear_o  <= 1'b0;
			err_o          <= 1'b0;

			if (wr && adr == `MRC_ADR_CTRL)
				cfg <= (cfg & ~(lane[`MRC_CTRL_W-1:0] & `MRC_CTRL_MASK)) |
				       (wb_dat_i[`MRC_CTRL_W-1:0] &
				        lane[`MRC_CTRL_W-1:0] & `MRC_CTRL_MASK);
			if (wr && adr == `MRC_ADR_COUNT)
				repeat_count <= (repeat_count & ~lane[`MRC_CNT_W-1:0]) |
				                (wb_dat_i[`MRC_CNT_W-1:0] &
				                 lane[`MRC_CNT_W-1:0]);
			if (wr && adr == `MRC_ADR_ERROR)
				err_code <= 16'h0000;

			case (state)
			ST_IDLE:
			begin
				if (cmd_rst)
				begin
					cont <= 1'b0;
					cfg[`MRC_B_STOPFAIL] <= 1'b0;
				end
				else if (cmd_single && cont)
				begin
					err_code <= `MRC_ERR_INIT;
					err_o    <= 1'b1;
				end
				else if (cmd_single)
				begin
					state        <= ST_RUN;
					block_mode   <= want_block;
					left         <= want_block ? repeat_count :
					                {{(`MRC_CNT_W-1){1'b0}}, 1'b1};
					meas_start_o <= 1'b1;
					pending_op_o <= 1'b1;
					auto_trigger_o <= self_trig;
					limit_clear_o  <= self_clr;
					stats_clear_o  <= cfg[`MRC_B_ABC] & cfg[`MRC_B_STATEN];
					stat_comp      <= cfg[`MRC_B_STATEN];
				end
				else if (cmd_on || cont)
				begin
					// start at once; restart after cancel
					cont         <= ~cmd_off;
					state        <= ST_RUN;
					block_mode   <= 1'b0;
					left         <= {{(`MRC_CNT_W-1){1'b0}}, 1'b1};
					meas_start_o <= 1'b1;
					pending_op_o <= 1'b1;
					auto_trigger_o <= self_trig;
					stats_clear_o  <= cmd_on;
					limit_clear_o  <= cmd_on & self_clr;
					stat_comp      <= ~cmd_on & stat_comp;
				end
				else if (cmd_off)
					cont <= 1'b0;
			end
			ST_RUN:
			begin
				if (cmd_cancel || cmd_rst)
				begin
					meas_cancel_o <= 1'b1;
					state         <= ST_IDLE;
					pending_op_o  <= 1'b0;
					stat_comp     <= 1'b0;
					if (cmd_rst)
					begin
						cont <= 1'b0;
						cfg[`MRC_B_STOPFAIL] <= 1'b0;
					end
				end
				else
				begin
					// A refused command must not swallow a completion.
					if (!cont && (cmd_on || cmd_off || cmd_single))
					begin
						err_code <= cmd_off ? `MRC_ERR_TRIG :
						            `MRC_ERR_INIT;
						err_o    <= 1'b1;
					end
					else if (cmd_single)
					begin
						err_code <= `MRC_ERR_INIT;
						err_o    <= 1'b1;
					end
					if (cont && cmd_on)
					begin
						stats_clear_o <= 1'b1;
						stat_comp     <= 1'b0;
						limit_clear_o <= self_clr;
						auto_trigger_o <= self_trig;
					end
					if (meas_done_i)
					begin
						if (cont && !cmd_off && !(cfg[`MRC_B_STOPFAIL] &&
						    cfg[`MRC_B_LIMEN] && limit_fail_i))
						begin
							meas_start_o   <= 1'b1;
							auto_trigger_o <= self_trig;
						end
						else if (block_mode && left > 16'h0001)
						begin
							left         <= left - 16'h0001;
							meas_start_o <= 1'b1;
						end
						else
						begin
							state        <= ST_IDLE;
							pending_op_o <= 1'b0;
							stat_comp    <= 1'b0;
						end
					end
					if (cmd_off)
						cont <= 1'b0;
				end
				if (cont && cfg[`MRC_B_STOPFAIL] && cfg[`MRC_B_LIMEN] &&
				    limit_fail_i)
					cont <= 1'b0;
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// Limit fail flag: a failure in the clearing cycle wins.
	always @*
	begin
		next_fail = limit_detect_o;
		if (limit_clear_o)
			next_fail = 1'b0;
		if (limit_fail_i && cfg[`MRC_B_LIMEN])
			next_fail = 1'b1;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			limit_detect_o      <= 1'b0;
			limit_annunciator_o <= 1'b0;
		end
		else
		begin
			limit_detect_o      <= next_fail;
			limit_annunciator_o <= next_fail;
		end
	end

	mrc_cnt #(.W(`MRC_CNT_W)) u_stat (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (stats_clear_o),
		.inc_i   (meas_done_i & state & cfg[`MRC_B_STATEN]),
		.count_o (stat_cnt)
	);

	mrc_cnt #(.W(`MRC_CNT_W)) u_pass (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (limit_clear_o),
		.inc_i   (limit_pass_i & cfg[`MRC_B_LIMEN]),
		.count_o (pass_cnt)
	);

	mrc_cnt #(.W(`MRC_CNT_W)) u_fail (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (limit_clear_o),
		.inc_i   (limit_fail_i & cfg[`MRC_B_LIMEN]),
		.count_o (fail_cnt)
	);

	// Read data is latched in the request cycle and held through ack.
	always @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (rd)
		begin
			case (adr)
			`MRC_ADR_CTRL:
				wb_dat_o <= {18'h00000, cfg[`MRC_CTRL_W-1:1], cont};
			`MRC_ADR_STATUS:
				wb_dat_o <= {23'h000000, stat_comp, 3'h0, limit_detect_o,
				             block_mode, state, pending_op_o, cont};
			`MRC_ADR_ERROR:
				wb_dat_o <= {16'h0000, err_code};
			`MRC_ADR_COUNT:
				wb_dat_o <= {16'h0000, repeat_count};
			`MRC_ADR_STATCNT:
				wb_dat_o <= {16'h0000, stat_cnt};
			`MRC_ADR_PASSCNT:
				wb_dat_o <= {16'h0000, pass_cnt};
			`MRC_ADR_FAILCNT:
				wb_dat_o <= {16'h0000, fail_cnt};
			default:
				wb_dat_o <= 32'h00000000;
			endcase
		end
	end
endmodule // mrc_top

// file: verification/mrc_assertions.sv
// Port-level checks of the run control block.
`include "mrc_map.vh"
module mrc_run_assertions (
	// System
	input wire       clk_i,
	input wire       rst_i,
	// Wishbone slave
	input wire       wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire       wb_ack_o,
	// Trigger and engine
	input wire       get_i,
	input wire       listen_i,
	input wire       meas_done_i,
	input wire       limit_fail_i,
	input wire       meas_start_o,
	input wire       meas_cancel_o,
	input wire       auto_trigger_o,
	input wire       stats_clear_o,
	input wire       limit_clear_o,
	// Status
	input wire       limit_detect_o,
	input wire       limit_annunciator_o,
	input wire       pending_op_o,
	input wire       err_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A command acts at the edge that samples ack, not at the request.
	wire cmd_w = wb_ack_o & wb_we_i & (wb_adr_i[4:2] == `MRC_ADR_CMD);
	wire cause = cmd_w | (get_i & listen_i);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_START_ONE: assert property (
		meas_start_o |=> !meas_start_o) else $error("long start");
	AST_CANCEL_ONE: assert property (
		meas_cancel_o |=> !meas_cancel_o) else $error("long cancel");
	AST_START_CAUSE: assert property (
		meas_start_o |-> $past(meas_done_i | cause | meas_cancel_o)
		|| $past(rst_i, 2)) else $error("start without cause");
	AST_PEND_RISE: assert property (
		$rose(pending_op_o) |-> meas_start_o) else $error("bad pending");
	AST_PEND_FALL: assert property (
		$fell(pending_op_o) |-> $past(meas_done_i | cause | rst_i))
		else $error("pending dropped");
	AST_ERR_CAUSE: assert property (
		err_o |-> $past(cause)) else $error("error without command");
	AST_STAT_CLR: assert property (
		stats_clear_o |-> $past(cause) || $past(rst_i, 2))
		else $error("stray statistics clear");
	AST_AUTO_TRIG: assert property (
		auto_trigger_o |-> meas_start_o || $past(cause))
		else $error("stray auto-trigger");
	AST_LIM_CLR: assert property (
		limit_clear_o && !limit_fail_i |=> !limit_detect_o)
		else $error("detect not cleared");
	AST_ANNUN: assert property (
		limit_annunciator_o == limit_detect_o) else $error("indicator");
	COV_RESTART: cover property (meas_done_i ##1 meas_start_o);
	COV_PEND_END: cover property ($fell(pending_op_o));
	COV_ERR: cover property (err_o);
endmodule // mrc_run_assertions

bind mrc_top mrc_run_assertions chk_u (
	.clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .get_i, .listen_i,
	.meas_done_i, .limit_fail_i, .meas_start_o, .meas_cancel_o,
	.auto_trigger_o,
	.stats_clear_o, .limit_clear_o, .limit_detect_o,
	.limit_annunciator_o, .pending_op_o, .err_o
);

// file: verification/mrc_engine_model.sv
// Behavioural measurement engine facing the run control block.
module mrc_engine_model (
	// System
	input  wire       clk_i,
	input  wire       rst_i,
	// Control from the block
	input  wire       start_i,
	input  wire       cancel_i,
	// Behaviour chosen by the bench
	input  wire [3:0] lat_i,
	input  wire       endless_i,
	input  wire       fail_i,
	// Results
	output reg        done_o = 1'b0,
	output reg        pass_o = 1'b0,
	output reg        fail_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [3:0] left = 4'h0;
	reg       busy = 1'b0;
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		pass_o <= 1'b0;
		fail_o <= 1'b0;
		if (rst_i)
			busy <= 1'b0;
		else if (start_i)
		begin
			busy <= 1'b1;
			left <= lat_i;
		end
		else if (cancel_i)
			busy <= 1'b0;
		else if (busy && !endless_i)
		begin
			if (left == 4'h0)
			begin
				busy   <= 1'b0;
				done_o <= 1'b1;
				pass_o <= !fail_i;
				fail_o <= fail_i;
			end
			else
				left <= left - 4'h1;
		end
	end
endmodule // mrc_engine_model

// file: verification/tb_measurement_run_control.sv
// Self-checking bench of the run control block.
`include "mrc_map.vh"
module tb_measurement_run_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [4:0]  wb_adr_i = 5'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic        get_i = 1'b0;
	logic        listen_i = 1'b0;
	logic [3:0]  lat = 4'h8;
	logic        endless = 1'b0;
	logic        fl = 1'b0;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, meas_done_i, limit_fail_i, limit_pass_i;
	wire         meas_start_o, meas_cancel_o, auto_trigger_o;
	wire         stats_clear_o, limit_clear_o, limit_detect_o;
	wire         limit_annunciator_o, pending_op_o, err_o;
	int          n_mismatch = 0, total_checks = 0, seed = 32'ha9a1bba6;
	int          n_st = 0, n_cn = 0, n_at = 0, n_sc = 0, n_lc = 0, n_er = 0;
	int          i, j, k, m, a, s, l;
	logic [31:0] q;
	logic [13:0] c;

	always #10 clk_i = !clk_i;

	mrc_top dut_u (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .get_i, .listen_i,
		.meas_done_i, .limit_fail_i, .limit_pass_i, .meas_start_o,
		.meas_cancel_o, .auto_trigger_o, .stats_clear_o, .limit_clear_o,
		.limit_detect_o, .limit_annunciator_o, .pending_op_o, .err_o
	);
	mrc_engine_model eng_u (
		.clk_i, .rst_i, .start_i(meas_start_o), .cancel_i(meas_cancel_o),
		.lat_i(lat), .endless_i(endless), .fail_i(fl),
		.done_o(meas_done_i), .pass_o(limit_pass_i), .fail_o(limit_fail_i)
	);

	always @(posedge clk_i)
	begin
		n_st <= n_st + meas_start_o;
		n_cn <= n_cn + meas_cancel_o;
		n_at <= n_at + auto_trigger_o;
		n_sc <= n_sc + stats_clear_o;
		n_lc <= n_lc + limit_clear_o;
		n_er <= n_er + err_o;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
	begin
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	end
	endtask

	// Outputs are looked at on the falling edge, where they have settled.
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wb(input logic w, input logic [2:0] ad,
		input logic [31:0] d, output logic [31:0] r);
	begin
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {ad, 2'b00};
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	end
	endtask

	task automatic cmd(input int b);
		logic [31:0] r;
		wb(1'b1, `MRC_ADR_CMD, 32'h1 << b, r);
	endtask

	task automatic wt(input logic v);
		int n;
	begin
		n = 0;
		do @(negedge clk_i); while (pending_op_o !== v && ++n < 300);
		chk("pending", v, pending_op_o);
	end
	endtask

	task automatic trig(input logic lis);
	begin
		@(posedge clk_i);
		listen_i <= lis;
		get_i    <= 1'b1;
		@(posedge clk_i);
		get_i    <= 1'b0;
	end
	endtask

	function automatic logic [31:0] exp_starts(input logic [13:0] v);
		return (v[3:2] == 2'h3 && v[10:8] < `MRC_FN_SPECIAL) ? 3 : 1;
	endfunction

	task automatic wrap_up();
	begin
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	// The whole run needs some 450 cycles; the margin covers slow blocks.
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc_n(3);
		chk("pending", 1, pending_op_o);
		chk("starts", 1, n_st);
		wb(0, `MRC_ADR_STATUS, 0, q);
		chk("cont", 1, q[0]);
		for (i = 0; i < 6; i++)
		begin
			lat <= 4'($random(seed));
			do @(negedge clk_i); while (meas_done_i !== 1'b1);
			cyc_n(1);
			chk("restart", 1, meas_start_o);
		end
		lat <= 4'hf;
		do @(negedge clk_i); while (meas_start_o !== 1'b1);
		cyc_n(1);
		m = n_st;
		cmd(`MRC_C_CANCEL);
		cyc_n(3);
		chk("cancel", 1, n_cn);
		chk("restart", m + 1, n_st);
		m = n_sc;
		cmd(`MRC_C_CONT_ON);
		cyc_n(2);
		chk("stat clear", m + 1, n_sc);
		wb(0, `MRC_ADR_STATCNT, 0, q);
		chk("stat count", 0, q);
		cmd(`MRC_C_SINGLE);
		wb(0, `MRC_ADR_ERROR, 0, q);
		chk("error", `MRC_ERR_INIT, q);
		cmd(`MRC_C_STDRST);
		wt(0);
		wb(0, `MRC_ADR_STATUS, 0, q);
		chk("cont", 0, q[0]);
		m = n_st;
		cyc_n(40);
		chk("idle", m, n_st);
		wb(1, `MRC_ADR_COUNT, 3, q);
		for (i = 0; i < 6; i++)
		begin
			c = (i == 0) ? 14'h006c : 14'($random(seed)) & 14'h077c;
			lat <= (i == 0) ? 4'hf : 4'($random(seed));
			wb(1, `MRC_ADR_CTRL, c, q);
			m = n_st;
			a = n_at;
			s = n_sc;
			l = n_lc;
			j = n_er;
			cmd(`MRC_C_SINGLE);
			cyc_n(2);
			chk("pending", 1, pending_op_o);
			for (k = 0; k < 3 && i == 0; k++)
			begin
				cmd(k);
				wb(0, `MRC_ADR_ERROR, 0, q);
				chk("error", k == 1 ? `MRC_ERR_TRIG : `MRC_ERR_INIT, q);
			end
			wt(0);
			chk("errors", i == 0 ? 3 : 0, n_er - j);
			chk("starts", exp_starts(c), n_st - m);
			chk("stat clear", c[3:2] == 2'h3, n_sc - s);
			chk("limit clear", c[5], n_lc - l);
			chk("auto trig", c[6], n_at - a);
		end
		wb(1, `MRC_ADR_CTRL, 14'h0032, q);
		fl <= 1'b1;
		cmd(`MRC_C_CONT_ON);
		wt(0);
		wb(0, `MRC_ADR_STATUS, 0, q);
		chk("cont", 0, q[0]);
		chk("detect", 1, limit_detect_o);
		chk("indicator", 1, limit_annunciator_o);
		wb(0, `MRC_ADR_FAILCNT, 0, q);
		chk("fail count", 1, q);
		wb(0, `MRC_ADR_PASSCNT, 0, q);
		chk("pass count", 0, q);
		fl <= 1'b0;
		cmd(`MRC_C_SINGLE);
		cyc_n(2);
		chk("detect", 0, limit_detect_o);
		chk("indicator", 0, limit_annunciator_o);
		wb(0, `MRC_ADR_FAILCNT, 0, q);
		chk("fail count", 0, q);
		wt(0);
		endless <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			wb(1, `MRC_ADR_CTRL, i << 12, q);
			m = n_st;
			a = n_cn;
			for (k = 0; k < 2; k++)
			begin
				trig(k);
				cyc_n(3);
			end
			chk("get start", (4'b0101 >> i) & 1, n_st - m);
			chk("get cancel", (4'b0010 >> i) & 1, n_cn - a);
		end
		cmd(`MRC_C_CONT_OFF);
		cyc_n(30);
		chk("pending", 1, pending_op_o);
		cmd(`MRC_C_CANCEL);
		wt(0);
		wrap_up();
	end
endmodule // tb_measurement_run_control
